// ===== dv/osbd_block_delivery_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module osbd_block_delivery_monitor
    import osbd_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              clk_en,
    input wire logic              dc_mode,
    input wire logic [CYC_W-1:0]  cycle_time,
    input wire logic [TIME_W-1:0] local_dc_time,
    input wire logic              block_release_pulse,
    input wire logic              internal_fault_flag,
    input wire logic [15:0]       input_status_word,
    input wire logic [15:0]       sample_counter,
    input wire logic [TIME_W-1:0] next_block_start_time,
    input wire logic              block_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ========================================================================
    // Release and result set
    rel_ready_a: assert property (
        clk_en && dc_mode && block_release_pulse |=> block_ready)
        else $error("release gave no block");
    no_spurious_a: assert property (
        clk_en && dc_mode && !block_release_pulse |=> !block_ready)
        else $error("block without release");
    count_step_a: assert property (
        block_ready && $past(clk_en)
            |-> sample_counter == $past(sample_counter) + 16'h0001)
        else $error("counter did not step by one");
    set_hold_a: assert property (
        !block_ready |-> $stable(sample_counter)
            && $stable(next_block_start_time))
        else $error("result set changed between releases");
    stamp_calc_a: assert property (
        block_ready && $past(clk_en) |-> next_block_start_time
            == $past(local_dc_time) + $past(cycle_time))
        else $error("wrong next start time");
    toggle_flip_a: assert property (
        block_ready && $past(clk_en)
            |-> input_status_word[15] != $past(input_status_word[15]))
        else $error("toggle bit did not flip");
    fault_live_a: assert property (
        clk_en |=> input_status_word[14] == $past(internal_fault_flag))
        else $error("internal fault bit wrong");
    error_sum_a: assert property (
        |{input_status_word[13], input_status_word[1:0]}
            |-> input_status_word[6])
        else $error("general error bit missing");
    cover property (block_ready && input_status_word[13]);
    cover property (block_ready && !dc_mode);
    cover property (block_ready && input_status_word[1]);
    cover property (!clk_en && block_release_pulse);
endmodule
bind osbd_block_delivery osbd_block_delivery_monitor mon_u
(
    .clk, .reset_n, .clk_en, .dc_mode, .cycle_time, .local_dc_time,
    .block_release_pulse, .internal_fault_flag, .input_status_word,
    .sample_counter, .next_block_start_time, .block_ready
);
`default_nettype wire

// ===== dv/osbd_block_delivery_tb.sv
`timescale 1ns/1ps
`default_nettype none
module osbd_block_delivery_tb
    import osbd_pkg::*;
;
    logic                    clk = 1'b0, reset_n = 1'b0, dc_mode = 1'b1;
    logic                    trig = 1'b0, rel = 1'b0, hr = 1'b0, acc;
    logic                    ifault = 1'b0, lim_en = 1'b0, poll = 1'b0;
    logic                    rdy, rng, tog = 1'b0, per = 1'b0, en = 1'b1;
    logic [1:0]              lim_code;
    logic [FACT_W-1:0]       factor = 7'h04;
    logic [CYC_W-1:0]        cyc = 32'h0000C350, osh, ish, oso, iso;
    logic [TIME_W-1:0]       dct = 64'h0, nbst, stamp, prev, fst;
    logic signed [CAL_W-1:0] cal = 17'sh00000;
    logic [SAMPLE_W-1:0]     lim = 16'h0032, pds;
    logic [IDX_W-1:0]        idx = 6'h00;
    logic [15:0]             sw, scnt, cnt = 16'h0000;
    logic [MAX_OS-1:0]       flags;
    int                      fails = 0, comparisons = 0, blocks, skips, b0, j;

    osbd_block_delivery dut_u
    (
        .clk(clk), .reset_n(reset_n), .clk_en(en), .dc_mode(dc_mode),
        .oversample_factor(factor), .cycle_time(cyc), .local_dc_time(dct),
        .sample_trigger_pulse(trig), .block_release_pulse(rel),
        .input_buffer_access(acc), .cal_value(cal), .high_range(hr),
        .internal_fault_flag(ifault), .limit_enable(lim_en),
        .limit_value(lim), .output_shift_time(osh), .input_shift_time(ish),
        .pd_index(idx), .input_status_word(sw), .sample_counter(scnt),
        .next_block_start_time(nbst), .sample_range_flags(flags),
        .range_active(rng), .pd_sample(pds), .block_ready(rdy),
        .output_shift_out(oso), .input_shift_out(iso)
    );
    osbd_master_model master_u
    (
        .clk(clk), .poll(poll), .block_ready(rdy), .sample_counter(scnt),
        .next_block_start_time(nbst), .cycle_time(cyc),
        .input_buffer_access(acc), .output_shift_time(osh),
        .input_shift_time(ish), .blocks(blocks), .skips(skips),
        .first_sample_time(fst)
    );
    // ========================================================================
    // Clock, local time at 40 ns a tick, run limit
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(negedge clk)
        dct <= dct + 64'h28;
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        close_out();
    end
    task automatic close_out();
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ========================================================================
    // One DC cycle of 50 us: n triggers, then release on its last clock
    task automatic blk(input int n, input logic signed [CAL_W-1:0] base,
                       input logic [3:0] m, input logic se);
        int i;
        for (i = 0; i < 1249; i++)
        begin
            @(negedge clk);
            trig = (i < n);
            cal = base + CAL_W'(i);
            hr = m[i % 4];
            rel = (i == 1248);
        end
        // Release edge lies behind us, so one call spans 1250 clocks
        @(negedge clk);
        rel = 1'b0;
        // Still the old value: the local time the release edge sampled
        stamp = dct;
        cnt = cnt + 16'h0001;
        tog = ~tog;
        check("ready", rdy, 1'b1);
        check("counter", scnt, cnt);
        check("toggle", sw[15], tog);
        check("stamp", nbst, stamp + cyc);
        if (per)
            check("period", nbst - prev, cyc);
        check("sync", sw[13], se);
        if (se)
            check("error", sw[6], 1'b1);
        if (n == 4)
            check("ranges", {rng, flags[3:0]}, {|m, m});
        prev = nbst;
        per = 1'b1;
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        check("reset", sw, 16'h0000);
        blk(4, 17'sh00064, 4'h4, 1'b0);
        // Held block must survive while the next one is filling
        for (j = 0; j < 4; j++)
        begin
            @(negedge clk);
            idx = IDX_W'(j);
            trig = 1'b1;
            @(negedge clk);
            trig = 1'b0;
            check("sample", pds, 16'h0064 + 16'(j));
        end
        check("date", fst, stamp);
        per = 1'b0;
        // The four triggers above already fill this next block
        blk(0, 17'sh00000, 4'h0, 1'b0);
        blk(3, 17'sh00010, 4'h0, 1'b1);
        blk(0, 17'sh00000, 4'h0, 1'b1);
        blk(4, 17'sh00020, 4'hB, 1'b0);
        lim_en = 1'b1;
        for (j = 0; j < 3; j++)
        begin
            blk(4, CAL_W'(46 + j), 4'h0, 1'b0);
            lim_code = (j == 0) ? 2'h1 : (j == 1) ? 2'h3 : 2'h2;
            check("limit", sw[3:2], lim_code);
        end
        blk(4, 17'sh08000, 4'hF, 1'b0);
        check("over", {sw[6], sw[1:0]}, 3'h6);
        blk(4, -17'sh08004, 4'h0, 1'b0);
        check("under", {sw[6], sw[1:0]}, 3'h5);
        idx = 6'h00;
        @(negedge clk);
        check("saturate", pds, 16'h8000);
        ifault = 1'b1;
        @(negedge clk);
        check("ifault", sw[14], 1'b1);
        ifault = 1'b0;
        check("shift", {oso, iso}, {osh, ish});
        // Enable low freezes all state, so this release must be ignored
        en = 1'b0;
        rel = 1'b1;
        @(negedge clk);
        en = 1'b1;
        rel = 1'b0;
        @(negedge clk);
        check("freeze", {rdy, scnt}, {1'b0, cnt});
        // Free mode: first read locks, later reads release, 200 us apart
        dc_mode = 1'b0;
        b0 = blocks;
        for (j = 0; j < 3; j++)
        begin
            poll = 1'b1;
            @(negedge clk);
            poll = 1'b0;
            repeat (4999) @(negedge clk);
        end
        check("free blocks", blocks - b0, 2);
        check("free count", scnt, cnt + 16'h0002);
        check("skips", skips, 0);
        close_out();
    end
endmodule
`default_nettype wire

// ===== dv/osbd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module osbd_master_model
    import osbd_pkg::*;
#(
    parameter logic [CYC_W-1:0] OUT_SHIFT = 32'h0000_1000,
    parameter logic [CYC_W-1:0] IN_SHIFT  = 32'h0000_2000
)
(
    input  wire logic              clk,
    input  wire logic              poll,
    input  wire logic              block_ready,
    input  wire logic [15:0]       sample_counter,
    input  wire logic [TIME_W-1:0] next_block_start_time,
    input  wire logic [CYC_W-1:0]  cycle_time,
    output logic                   input_buffer_access,
    output logic [CYC_W-1:0]       output_shift_time,
    output logic [CYC_W-1:0]       input_shift_time,
    output int                     blocks,
    output int                     skips,
    output logic [TIME_W-1:0]      first_sample_time
);
    logic        pend = 1'b0;
    logic [15:0] last = 16'h0000;
    int          nblk = 0;
    int          nskip = 0;
    // ========================================================================
    // Static shift times, fixed once at start
    assign output_shift_time = OUT_SHIFT;
    assign input_shift_time  = IN_SHIFT;
    // Counters kept inside so each output has a single driver
    assign blocks = nblk;
    assign skips  = nskip;
    // ========================================================================
    // Buffer reads; the bench spaces polls to 200 us with a whole interval
    always @(posedge clk)
        pend <= poll;
    always @(negedge clk)
        input_buffer_access <= pend;
    // Reader checks the counter and dates sample one of each block
    always @(negedge clk)
    begin
        if (block_ready === 1'b1)
        begin
            if (nblk > 0 && sample_counter !== last + 16'h0001)
                nskip <= nskip + 1;
            last <= sample_counter;
            nblk <= nblk + 1;
            first_sample_time <= next_block_start_time
                               - cycle_time;
        end
    end
endmodule
`default_nettype wire

// ===== hw/osbd_block_delivery.sv
`timescale 1ns/1ps
`default_nettype none
module osbd_block_delivery
    import osbd_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       clk_en,
    input  wire logic                       dc_mode,
    input  wire logic [FACT_W-1:0]          oversample_factor,
    input  wire logic [CYC_W-1:0]           cycle_time,
    input  wire logic [TIME_W-1:0]          local_dc_time,
    input  wire logic                       sample_trigger_pulse,
    input  wire logic                       block_release_pulse,
    input  wire logic                       input_buffer_access,
    input  wire logic signed [CAL_W-1:0]    cal_value,
    input  wire logic                       high_range,
    input  wire logic                       internal_fault_flag,
    input  wire logic                       limit_enable,
    input  wire logic signed [SAMPLE_W-1:0] limit_value,
    input  wire logic [CYC_W-1:0]           output_shift_time,
    input  wire logic [CYC_W-1:0]           input_shift_time,
    input  wire logic [IDX_W-1:0]           pd_index,
    output logic [15:0]                     input_status_word,
    output logic [15:0]                     sample_counter,
    output logic [TIME_W-1:0]               next_block_start_time,
    output logic [MAX_OS-1:0]               sample_range_flags,
    output logic                            range_active,
    output logic [SAMPLE_W-1:0]             pd_sample,
    output logic                            block_ready,
    output logic [CYC_W-1:0]                output_shift_out,
    output logic [CYC_W-1:0]                input_shift_out
);
    // ========================================================================
    // Internal sample clock for operation without distributed clocks
    // Accumulator spreads factor ticks over the measured access period
    // without a divider; jitter is one system clock at most.
    osbd_lock_type     lock_state;
    osbd_lock_type     next_lock_state;
    logic [CYC_W-1:0]  period_cnt;
    logic [CYC_W-1:0]  next_period_cnt;
    logic [CYC_W-1:0]  period_len;
    logic [CYC_W-1:0]  next_period_len;
    logic [CYC_W-1:0]  phase_acc;
    logic [CYC_W-1:0]  next_phase_acc;
    logic [CYC_W-1:0]  acc_sum;
    logic              int_tick;

    always_comb
    begin
        next_lock_state = lock_state;
        next_period_cnt = period_cnt + CYC_W'(1);
        next_period_len = period_len;
        acc_sum         = phase_acc + CYC_W'(oversample_factor);
        next_phase_acc  = acc_sum;
        int_tick        = 1'b0;
        if (lock_state == OSBD_LOCKED && acc_sum >= period_len)
        begin
            next_phase_acc = acc_sum - period_len;
            int_tick       = !dc_mode;
        end
        if (input_buffer_access && !dc_mode)
        begin
            next_period_len = period_cnt + CYC_W'(1);
            next_period_cnt = '0;
            next_phase_acc  = '0;
            next_lock_state = OSBD_LOCKED;
        end
        if (dc_mode)
        begin
            next_lock_state = OSBD_UNLOCKED;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_state <= OSBD_UNLOCKED;
            period_cnt <= '0;
            period_len <= '0;
            phase_acc  <= '0;
        end
        else if (clk_en)
        begin
            lock_state <= next_lock_state;
            period_cnt <= next_period_cnt;
            period_len <= next_period_len;
            phase_acc  <= next_phase_acc;
        end
    end

    // ========================================================================
    // Trigger and release selection
    // No control word exists: only configuration and pulses steer the block.
    logic trig;
    logic rel;
    assign trig = dc_mode ? sample_trigger_pulse : int_tick;
    assign rel  = dc_mode ? block_release_pulse
                          : (input_buffer_access && lock_state == OSBD_LOCKED);

    // ========================================================================
    // Fill side: buffer being filled plus per-block range tracking
    logic [SAMPLE_W-1:0] fill_buf [MAX_OS];
    logic [MAX_OS-1:0]   fill_range;
    logic [FACT_W-1:0]   fill_cnt;
    logic [FACT_W-1:0]   next_fill_cnt;
    logic [FACT_W:0]     conv_cnt;
    logic [FACT_W:0]     next_conv_cnt;
    logic                acc_over;
    logic                next_acc_over;
    logic                acc_under;
    logic                next_acc_under;
    logic [1:0]          acc_limit;
    logic [1:0]          next_acc_limit;
    logic                acc_hi;
    logic                next_acc_hi;
    logic                store;
    logic [SAMPLE_W-1:0] sat_value;
    logic                s_over;
    logic                s_under;
    logic [1:0]          s_limit;
    logic [IDX_W-1:0]    wr_idx;

    always_comb
    begin
        s_over  = cal_value > CAL_MAX;
        s_under = cal_value < CAL_MIN;
        if (s_over)
            sat_value = CAL_MAX[SAMPLE_W-1:0];
        else if (s_under)
            sat_value = CAL_MIN[SAMPLE_W-1:0];
        else
            sat_value = cal_value[SAMPLE_W-1:0];
        if (!limit_enable)
            s_limit = LIM_OFF;
        else if ($signed(sat_value) < limit_value)
            s_limit = LIM_BELOW;
        else if ($signed(sat_value) == limit_value)
            s_limit = LIM_EQUAL;
        else
            s_limit = LIM_ABOVE;
        // Samples beyond the factor are counted but dropped
        store  = trig
              && (rel ? 1'b1 : (fill_cnt < oversample_factor));
        wr_idx = rel ? '0 : fill_cnt[IDX_W-1:0];
        next_fill_cnt  = fill_cnt;
        next_conv_cnt  = conv_cnt;
        next_acc_over  = acc_over;
        next_acc_under = acc_under;
        next_acc_limit = acc_limit;
        next_acc_hi    = acc_hi;
        if (rel)
        begin
            next_fill_cnt  = '0;
            next_conv_cnt  = '0;
            next_acc_over  = 1'b0;
            next_acc_under = 1'b0;
            next_acc_hi    = 1'b0;
        end
        if (trig && (&conv_cnt) == 1'b0)
            next_conv_cnt = next_conv_cnt + (FACT_W+1)'(1);
        if (store)
        begin
            next_fill_cnt  = next_fill_cnt + FACT_W'(1);
            next_acc_over  = next_acc_over | s_over;
            next_acc_under = next_acc_under | s_under;
            next_acc_limit = s_limit;
            next_acc_hi    = next_acc_hi | high_range;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fill_cnt   <= '0;
            conv_cnt   <= '0;
            acc_over   <= 1'b0;
            acc_under  <= 1'b0;
            acc_limit  <= LIM_OFF;
            acc_hi     <= 1'b0;
            fill_range <= '0;
        end
        else if (clk_en)
        begin
            fill_cnt  <= next_fill_cnt;
            conv_cnt  <= next_conv_cnt;
            acc_over  <= next_acc_over;
            acc_under <= next_acc_under;
            acc_limit <= next_acc_limit;
            acc_hi    <= next_acc_hi;
            if (store)
                fill_range[wr_idx] <= high_range;
        end
    end

    // Sample memory needs no reset; unused slots are never delivered valid
    always_ff @(posedge clk)
    begin
        if (clk_en && store)
            fill_buf[wr_idx] <= sat_value;
    end

    // ========================================================================
    // Held block: separate copy so sampling goes on while it awaits reading
    logic [SAMPLE_W-1:0] held_buf [MAX_OS];

    generate
        for (genvar i = 0; i < MAX_OS; i++)
        begin : g_held
            always_ff @(posedge clk)
            begin
                if (clk_en && rel)
                    held_buf[i] <= fill_buf[i];
            end
        end
    endgenerate

    // ========================================================================
    // Release: status word, counter, timestamp and range flags as one set
    logic [15:0]        next_status;
    logic [15:0]        next_counter;
    logic [TIME_W-1:0]  next_time;
    logic [MAX_OS-1:0]  next_flags;
    logic               next_range_active;
    logic               next_ready;
    logic               sync_fault;
    logic               any_fault;

    always_comb
    begin
        sync_fault = (dc_mode && conv_cnt == '0)
                   || (conv_cnt != {1'b0, oversample_factor});
        any_fault  = acc_over || acc_under || internal_fault_flag || sync_fault;
        next_status       = input_status_word;
        next_counter      = sample_counter;
        next_time         = next_block_start_time;
        next_flags        = sample_range_flags;
        next_range_active = range_active;
        next_ready        = 1'b0;
        next_status[SW_IFAULT] = internal_fault_flag;
        if (rel)
        begin
            next_status[SW_TOGGLE] = ~input_status_word[SW_TOGGLE];
            next_status[SW_SYNC]   = sync_fault;
            next_status[SW_ERROR]  = any_fault;
            next_status[SW_OVER]   = acc_over;
            next_status[SW_UNDER]  = acc_under;
            next_status[SW_LIM_HI:SW_LIM_LO] = acc_limit;
            next_counter      = sample_counter + 16'h0001;
            // Start of the next block is one cycle time after this release
            next_time = local_dc_time + TIME_W'(cycle_time);
            next_flags        = fill_range;
            next_range_active = acc_hi;
            next_ready        = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            input_status_word     <= SW_RESET;
            sample_counter        <= '0;
            next_block_start_time <= '0;
            sample_range_flags    <= '0;
            range_active          <= 1'b0;
            block_ready           <= 1'b0;
        end
        else if (clk_en)
        begin
            input_status_word     <= next_status;
            sample_counter        <= next_counter;
            next_block_start_time <= next_time;
            sample_range_flags    <= next_flags;
            range_active          <= next_range_active;
            block_ready           <= next_ready;
        end
    end

    // ========================================================================
    // Read port into held block and static shift values
    // Shift times are latched continuously; the master keeps them static.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pd_sample        <= '0;
            output_shift_out <= '0;
            input_shift_out  <= '0;
        end
        else if (clk_en)
        begin
            pd_sample        <= held_buf[pd_index];
            output_shift_out <= output_shift_time;
            input_shift_out  <= input_shift_time;
        end
    end
endmodule
`default_nettype wire

// ===== hw/osbd_pkg.sv
// Operation
// - DC mode: fault flag set when a release comes with no fresh block
// - Fault flag set when converted count differs from delivered slot count
// - Each cycle deliver 64-bit start time of the next block from local clock
// - Start time advances by exactly the task cycle time per cycle
// - Sample counter increments by one every process data cycle
// - Per-sample high range flags plus per-cycle high range active flag
// - Each trigger converts one sample into the buffer up to the factor
// - Release presents the filled buffer and captures next start time
// - Released block and its start time are assembled as one set
// - Status bit 15 toggles with each new delivered value
// - Status bit 14 is one while an internal fault is present
// - Status bit 13 is one when a sync fault occurred last cycle
// - Status bit 6 is general fault, set with over or under range
// - Status bit 1 over upper threshold, bit 0 under lower threshold
// - Limit field: 0x01 below, 0x03 equal, 0x02 above the limit
// - Over range judged on calibrated value beyond largest 16-bit code
// - No control word; behaviour set by configuration and sync pulses
// - Without DC, sampling clock locks to master access of input buffer
package osbd_pkg;
    // ========================================================================
    // Sizes
    localparam int SAMPLE_W   = 16;
    localparam int CAL_W      = 17;
    localparam int MAX_OS     = 64;
    localparam int IDX_W      = 6;
    localparam int FACT_W     = 7;
    localparam int TIME_W     = 64;
    localparam int CYC_W      = 32;
    // ========================================================================
    // Status word layout
    localparam int SW_TOGGLE  = 15;
    localparam int SW_IFAULT  = 14;
    localparam int SW_SYNC    = 13;
    localparam int SW_ERROR   = 6;
    localparam int SW_LIM_HI  = 3;
    localparam int SW_LIM_LO  = 2;
    localparam int SW_OVER    = 1;
    localparam int SW_UNDER   = 0;
    localparam logic [15:0] SW_RESET = 16'h0000;
    // ========================================================================
    // Limit codes and range thresholds
    localparam logic [1:0] LIM_OFF   = 2'h0;
    localparam logic [1:0] LIM_BELOW = 2'h1;
    localparam logic [1:0] LIM_ABOVE = 2'h2;
    localparam logic [1:0] LIM_EQUAL = 2'h3;
    localparam logic signed [CAL_W-1:0] CAL_MAX = 17'sh07FFF;
    localparam logic signed [CAL_W-1:0] CAL_MIN = -17'sh08000;
    // ========================================================================
    // Bus cycle floors kept by the master
    localparam int MIN_CYCLE_DC_US   = 50;
    localparam int MIN_CYCLE_FREE_US = 200;
    // ========================================================================
    // Free-running lock states
    typedef enum logic [1:0]
    {
        OSBD_UNLOCKED = 2'b00,
        OSBD_LOCKED   = 2'b01
    } osbd_lock_type;
endpackage
